// ==== verif/esd_core_asserts.sv ====
// Port checks for the stack-op and operand decode block.
// Assumes a bind to esd_core: one clock, synchronous active-high reset.
`timescale 1ns/1ns
module esd_core_asserts #(
  parameter int PC_W = 21
) (
  // Inputs of the block
  input wire logic                              mclk_i,
  input wire logic                              srst_i,
  input wire logic                              ext_en_i,
  input wire logic [3:0]                        bank_select_reg_i,
  input wire logic                              instr_valid_i,
  input wire logic [15:0]                       instr_i,
  input wire logic [PC_W-1:0]                   return_stack_top_i,
  input wire esd_pkg::esd_opnd_req_type         opnd_req_i,
  // Outputs of the block
  input wire esd_pkg::esd_mem_wr_type           mem_wr_o,
  input wire logic                              pc_load_o,
  input wire logic [PC_W-1:0]                   pc_value_o,
  input wire logic                              stack_pop_o,
  input wire logic                              busy_o,
  input wire logic                              push_literal_op_o,
  input wire logic                              pointer_subtract_op_o,
  input wire logic                              stack_sub_return_op_o,
  input wire logic [2:0][esd_pkg::ADDR_W-1:0]   ptr_o,
  input wire esd_pkg::esd_opnd_rsp_type         opnd_rsp_o
);
  // ********
  // Checks
  // ********
  default clocking @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  logic       go;
  logic [7:0] f;
  logic       push, sub, ret, idx;
  assign go   = instr_valid_i && ext_en_i && !busy_o;
  assign f    = opnd_req_i.file;
  assign push = go && instr_i[15:8] == esd_pkg::OPC_PUSH_LIT;
  assign sub  = go && instr_i[15:8] == esd_pkg::OPC_PTR_SUB && instr_i[7:6] != 2'h3;
  assign ret  = go && instr_i[15:8] == esd_pkg::OPC_PTR_SUB && instr_i[7:6] == 2'h3;
  assign idx  = opnd_req_i.valid && ext_en_i && !opnd_req_i.access && f <= 8'h5f;
  // The cycle after a return must be a bare no-op.
  sequence s_ret_tail;
    busy_o ##1 !(busy_o || mem_wr_o.we || pc_load_o || pointer_subtract_op_o);
  endsequence
  a_push_store: assert property (push |=> mem_wr_o.we &&
    push_literal_op_o &&
    mem_wr_o.addr == $past(ptr_o[2]) && mem_wr_o.data == $past(instr_i[7:0]))
    else $error("push store wrong");
  a_push_dec: assert property (push |=> ptr_o[2] == $past(ptr_o[2]) - 12'h001)
    else $error("push pointer step wrong");
  a_sub_ptr: assert property (sub |=> pointer_subtract_op_o &&
    ptr_o[$past(instr_i[7:6])] == $past(ptr_o[instr_i[7:6]]) - 12'($past(instr_i[5:0])))
    else $error("pointer subtract wrong");
  a_ret_load: assert property (ret |=> pc_load_o && stack_pop_o &&
    stack_sub_return_op_o && $stable(ptr_o[1:0]) && pc_value_o == $past(return_stack_top_i) &&
    ptr_o[2] == $past(ptr_o[2]) - 12'($past(instr_i[5:0])))
    else $error("return wrong");
  a_ret_nop: assert property (ret |=> s_ret_tail)
    else $error("return second cycle not idle");
  a_opnd_idx: assert property (idx |=>
    opnd_rsp_o.indexed && opnd_rsp_o.addr == $past(ptr_o[2]) + {4'h0, $past(f)})
    else $error("indexed operand wrong");
  a_opnd_lit: assert property (opnd_req_i.valid && !idx |=> !opnd_rsp_o.indexed &&
    opnd_rsp_o.addr == $past(opnd_req_i.access ? {bank_select_reg_i, f} :
    {(f < 8'h60) ? 4'h0 : 4'hf, f})) else $error("literal operand wrong");
  a_opnd_dest: assert property (opnd_req_i.valid |=> opnd_rsp_o.valid &&
    opnd_rsp_o.to_wreg == !$past(opnd_req_i.dest)) else $error("destination wrong");
  a_not_ours: assert property (!(push || sub || ret) |=>
    !(mem_wr_o.we || pc_load_o || stack_pop_o)) else $error("refused op acted");
endmodule

// ==== verif/esd_ret_stack.sv ====
// Return stack model at the far side; each pop shows the next entry.
// Assumes pops are one-cycle strobes on mclk_i.
`timescale 1ns/1ns
module esd_ret_stack #(
  parameter int PC_W = 21
) (
  // Clock, reset and pop strobe
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic        pop_i,
  // Current top entry
  output logic [PC_W-1:0]  top_o
);
  int depth;
  always @(posedge mclk_i) begin
    if (srst_i)
      depth <= 0;
    else if (pop_i)
      depth <= depth + 1;
  end
  // Entries differ in many bits so a stale top is seen at once.
  assign top_o = PC_W'(32'h1a5c3 + depth * 32'h2f1);
endmodule

// ==== verif/tb_top.sv ====
// Self-checking bench for esd_core with a return stack model.
// Assumes a 20 MHz clock and the hand-over timing of the block.
`timescale 1ns/1ns
module tb_top;
  localparam int PC_W = 21;
  logic                      mclk_i = 1'b0;
  logic                      srst_i = 1'b1;
  logic                      ext_en_i = 1'b0;
  logic [3:0]                bank_select_reg_i = 4'h0;
  logic                      instr_valid_i = 1'b0;
  logic [15:0]               instr_i = 16'h0000;
  esd_pkg::esd_ptr_wr_type   ptr_wr_i = '0;
  esd_pkg::esd_opnd_req_type opnd_req_i = '0;
  logic [PC_W-1:0]           return_stack_top_i, pc_value_o;
  esd_pkg::esd_mem_wr_type   mem_wr_o;
  esd_pkg::esd_opnd_rsp_type opnd_rsp_o;
  logic                      pc_load_o, stack_pop_o, busy_o;
  logic                      push_literal_op_o, pointer_subtract_op_o, stack_sub_return_op_o;
  logic [2:0][11:0]          ptr_o;
  integer                    seed = 32'h44e2d44f;
  int                        bad_count = 0, n_checks = 0, n_ret = 0, cycles = 0, i;
  logic                      skip = 1'b0;
  logic [11:0]               w12;
  logic [11:0]               p [0:2] = '{default: 12'h000};
  logic [19:0]               mem_q [$];
  logic [13:0]               opq [$];
  logic [PC_W-1:0]           pcq [$];
  always #25 mclk_i = ~mclk_i;
  esd_core #(.PC_W(PC_W)) dut_u (.mclk_i, .srst_i, .ext_en_i, .bank_select_reg_i,
    .instr_valid_i, .instr_i, .ptr_wr_i, .return_stack_top_i, .opnd_req_i, .mem_wr_o,
    .pc_load_o, .pc_value_o, .stack_pop_o, .busy_o, .push_literal_op_o,
    .pointer_subtract_op_o, .stack_sub_return_op_o, .ptr_o, .opnd_rsp_o);
  esd_ret_stack #(.PC_W(PC_W)) stack_u (.mclk_i, .srst_i, .pop_i(stack_pop_o),
    .top_o(return_stack_top_i));
  // ********
  // Checking
  // ********
  task automatic check(string what, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  function automatic logic [PC_W-1:0] top_of(int n);
    return PC_W'(32'h1a5c3 + n * 32'h2f1);
  endfunction
  // Outputs are read at the edge, before that edge's updates land.
  always @(posedge mclk_i) begin
    cycles++;
    if (cycles == 3000) begin
      bad_count++;
      summarize();
    end
  end
  always @(posedge mclk_i) begin
    if (!srst_i && mem_wr_o.we)
      check("mem_wr", {mem_wr_o.addr, mem_wr_o.data},
            mem_q.size() ? mem_q.pop_front() : 'x);
    if (!srst_i && opnd_rsp_o.valid)
      check("operand", {opnd_rsp_o.addr, opnd_rsp_o.indexed, opnd_rsp_o.to_wreg},
            opq.size() ? opq.pop_front() : 'x);
    if (!srst_i && pc_load_o)
      check("pc", pc_value_o, pcq.size() ? pcq.pop_front() : 'x);
  end
  // ********
  // Stimulus
  // ********
  // One cycle of instruction plus a random operand request, with expectations noted.
  task automatic cyc(logic v, logic [15:0] w, logic en);
    logic [7:0]  f;
    logic        a, d, ix;
    @(posedge mclk_i);
    f = 8'($random(seed));
    a = 1'($random(seed));
    d = 1'($random(seed));
    ix = en && !a && f <= 8'h5f;
    opq.push_back({ix ? p[2] + {4'h0, f} : a ? {bank_select_reg_i, f} :
                   {(f < 8'h60) ? 4'h0 : 4'hf, f}, ix, !d});
    opnd_req_i <= '{1'b1, f, a, d};
    ext_en_i <= en;
    instr_valid_i <= v;
    instr_i <= w;
    if (skip)
      skip = 1'b0;
    else if (v && en && w[15:8] == 8'hea) begin
      mem_q.push_back({p[2], w[7:0]});
      p[2] = p[2] - 12'h001;
    end else if (v && en && w[15:8] == 8'he9) begin
      p[w[7:6] == 2'h3 ? 2 : w[7:6]] -= 12'(w[5:0]);
      if (w[7:6] == 2'h3) begin
        pcq.push_back(top_of(n_ret));
        n_ret++;
        skip = 1'b1;
      end
    end
  endtask
  initial begin
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    bank_select_reg_i <= 4'($random(seed));
    // Select 3 is a load the block must ignore, so the model keeps its pointers.
    for (i = 0; i < 4; i++) begin
      @(posedge mclk_i);
      w12 = 12'($random(seed)) | 12'h040;
      ptr_wr_i <= '{1'b1, w12, 2'(i)};
      if (i < 3)
        p[i] = w12;
    end
    @(posedge mclk_i);
    ptr_wr_i <= '0;
    cyc(1'b1, 16'heaff, 1'b1);
    cyc(1'b1, 16'hea00, 1'b1);
    for (i = 0; i < 4; i++)
      cyc(1'b1, {8'he9, 2'(i), 6'h3f}, 1'b1);
    cyc(1'b1, 16'hea55, 1'b1);
    cyc(1'b1, 16'he9c1, 1'b1);
    cyc(1'b1, 16'he9c0, 1'b1);
    cyc(1'b1, 16'heaa5, 1'b0);
    cyc(1'b1, 16'heb12, 1'b1);
    for (i = 0; i < 80; i++)
      cyc(1'($random(seed)), {6'h3a, 2'($random(seed)), 8'($random(seed))},
          ($random(seed) & 3) != 0);
    cyc(1'b0, 16'h0000, 1'b1);
    cyc(1'b0, 16'h0000, 1'b1);
    // Stop operand requests and let the last answers drain before the final count.
    @(posedge mclk_i);
    opnd_req_i <= '0;
    repeat (2) @(posedge mclk_i);
    for (i = 0; i < 3; i++)
      check("pointer", ptr_o[i], p[i]);
    check("leftover", mem_q.size() + opq.size() + pcq.size(), 0);
    summarize();
  end
endmodule
bind esd_core esd_core_asserts #(.PC_W(PC_W)) chk_u (.mclk_i, .srst_i, .ext_en_i,
  .bank_select_reg_i, .instr_valid_i, .instr_i, .return_stack_top_i, .opnd_req_i,
  .mem_wr_o, .pc_load_o, .pc_value_o, .stack_pop_o, .busy_o, .pointer_subtract_op_o,
  .ptr_o, .opnd_rsp_o, .push_literal_op_o, .stack_sub_return_op_o);

// ==== verilog/esd_core.sv ====
// Extended stack-op execute and indexed-operand decode for an 8-bit core.
// Assumes fetch, data memory and return stack share mclk_i; all inputs synchronous.
`timescale 1ns/1ns
module esd_core #(
  parameter int PC_W = 21
) (
  // Clock and reset
  input  wire logic                                    mclk_i,
  input  wire logic                                    srst_i,
  // Configuration
  input  wire logic                                    ext_en_i,
  input  wire logic [3:0]                              bank_select_reg_i,
  // Instruction from fetch
  input  wire logic                                    instr_valid_i,
  input  wire logic [15:0]                             instr_i,
  // Pointer load from the core
  input  wire esd_pkg::esd_ptr_wr_type                 ptr_wr_i,
  // Return stack
  input  wire logic [PC_W-1:0]                         return_stack_top_i,
  // Standard operand request
  input  wire esd_pkg::esd_opnd_req_type               opnd_req_i,
  // Data memory write
  output esd_pkg::esd_mem_wr_type                      mem_wr_o,
  // Program counter load and stack pop
  output logic                                         pc_load_o,
  output logic [PC_W-1:0]                              pc_value_o,
  output logic                                         stack_pop_o,
  // Status
  output logic                                         busy_o,
  output logic                                         push_literal_op_o,
  output logic                                         pointer_subtract_op_o,
  output logic                                         stack_sub_return_op_o,
  output logic [esd_pkg::NUM_PTR-1:0][esd_pkg::ADDR_W-1:0] ptr_o,
  // Resolved operand
  output esd_pkg::esd_opnd_rsp_type                    opnd_rsp_o
);

  // ************************************************************
  // Parameter check
  // ************************************************************
  // Eight bits is the smallest useful program space; 32 is the widest return entry carried.
  if (PC_W < 8 || PC_W > 32) begin : g_pc_w_check
    $error("PC_W must lie between 8 and 32.");
  end
  // The select field must sit directly above the immediate in the low byte.
  if (esd_pkg::SEL_POS != esd_pkg::IMM6_W || esd_pkg::SEL_POS + 2 != 8) begin : g_field_check
    $error("The select field must occupy bits 7 and 6 of the instruction.");
  end
  // A 2-bit select with one code reserved for the return variant names three pointers.
  if (esd_pkg::NUM_PTR != 3) begin : g_ptr_count_check
    $error("NUM_PTR must be 3.");
  end
  if (esd_pkg::SOFT_SP_IDX >= esd_pkg::NUM_PTR) begin : g_sp_index_check
    $error("The soft stack pointer index must name an existing pointer.");
  end
  // The index window must end below the split of the access bank.
  if (esd_pkg::INDEX_MAX >= esd_pkg::ACC_LOW_LIMIT) begin : g_window_check
    $error("The index window must end below the access bank split.");
  end
  // The banked form joins four bank bits with an 8-bit operand.
  if (esd_pkg::ADDR_W != 12) begin : g_addr_w_check
    $error("ADDR_W must be 12 to match bank plus operand.");
  end

  // ************************************************************
  // State
  // ************************************************************
  typedef struct packed {
    esd_pkg::esd_phase_type                            phase;
    logic [esd_pkg::NUM_PTR-1:0][esd_pkg::ADDR_W-1:0]  ptr;
    esd_pkg::esd_mem_wr_type                           mem_wr;
    logic                                              pc_load;
    logic [PC_W-1:0]                                   pc_value;
    logic                                              stack_pop;
    logic                                              push_op;
    logic                                              sub_op;
    logic                                              ret_op;
    logic                                              busy;
    esd_pkg::esd_opnd_rsp_type                         opnd;
  } esd_state_type;

  esd_state_type             st;
  esd_state_type             next_st;
  esd_pkg::esd_opnd_rsp_type opnd_comb;

  function automatic logic [esd_pkg::ADDR_W-1:0] ptr_sub(
    input logic [esd_pkg::ADDR_W-1:0] p,
    input logic [esd_pkg::IMM6_W-1:0] k
  );
    ptr_sub = p - {{(esd_pkg::ADDR_W-esd_pkg::IMM6_W){1'b0}}, k};
  endfunction

  // Opcode match on the high byte, shared by both extended families.
  function automatic logic opc_hit(
    input logic [15:0] word,
    input logic [7:0]  opc
  );
    opc_hit = (word[15:8] == opc);
  endfunction

  // ************************************************************
  // Operand address
  // ************************************************************
  // The index form exists only while the extension is enabled.
  esd_opnd_addr u_opnd_addr (
    .req_i                (opnd_req_i),
    .ext_en_i             (ext_en_i),
    .bank_select_reg_i    (bank_select_reg_i),
    .soft_stack_pointer_i (st.ptr[esd_pkg::SOFT_SP_IDX]),
    .rsp_o                (opnd_comb)
  );

  // ************************************************************
  // Decode and execute
  // ************************************************************
  logic [1:0]                sel;
  logic [esd_pkg::IMM6_W-1:0] imm6;
  logic                      take;

  always_comb begin
    next_st           = st;
    sel               = instr_i[esd_pkg::SEL_POS +: 2];
    imm6              = instr_i[esd_pkg::IMM6_W-1:0];
    take              = instr_valid_i && ext_en_i && (st.phase == esd_pkg::ST_EXEC);
    next_st.mem_wr.we = 1'b0;
    next_st.pc_load   = 1'b0;
    next_st.stack_pop = 1'b0;
    next_st.push_op   = 1'b0;
    next_st.sub_op    = 1'b0;
    next_st.ret_op    = 1'b0;
    next_st.busy      = 1'b0;
    next_st.opnd      = opnd_comb;
    // A core pointer load is applied first; an instruction writing the same pointer this cycle overrides it.
    if (ptr_wr_i.load && ptr_wr_i.sel < 2'(esd_pkg::NUM_PTR)) begin
      next_st.ptr[ptr_wr_i.sel] = ptr_wr_i.value;
    end
    case (st.phase)
      esd_pkg::ST_EXEC: begin
        if (take && opc_hit(instr_i, esd_pkg::OPC_PUSH_LIT)) begin
          // Store at the current pointer, then step it down, all in one cycle.
          next_st.mem_wr.we   = 1'b1;
          next_st.mem_wr.addr = st.ptr[esd_pkg::SOFT_SP_IDX];
          next_st.mem_wr.data = instr_i[7:0];
          next_st.ptr[esd_pkg::SOFT_SP_IDX] =
            st.ptr[esd_pkg::SOFT_SP_IDX] - 12'h001;
          next_st.push_op     = 1'b1;
        end else if (take && opc_hit(instr_i, esd_pkg::OPC_PTR_SUB)) begin
          if (sel == esd_pkg::SEL_SUB_RET) begin
            // Only the soft stack pointer is touched, then return.
            next_st.ptr[esd_pkg::SOFT_SP_IDX] =
              ptr_sub(st.ptr[esd_pkg::SOFT_SP_IDX], imm6);
            next_st.pc_load   = 1'b1;
            next_st.pc_value  = return_stack_top_i;
            next_st.stack_pop = 1'b1;
            next_st.ret_op    = 1'b1;
            next_st.phase     = esd_pkg::ST_RET_NOP;
            next_st.busy      = 1'b1;
          end else begin
            next_st.ptr[sel] = ptr_sub(st.ptr[sel], imm6);
            next_st.sub_op   = 1'b1;
          end
        end
      end
      esd_pkg::ST_RET_NOP: begin
        // Second cycle while the target is fetched: no action, input ignored.
        next_st.phase = esd_pkg::ST_EXEC;
      end
      default: begin
        next_st.phase = esd_pkg::ST_EXEC;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (srst_i) begin
      st.phase     <= esd_pkg::ST_EXEC;
      st.ptr       <= '{default: esd_pkg::PTR_RESET};
      st.mem_wr    <= '0;
      st.pc_load   <= 1'b0;
      st.pc_value  <= '0;
      st.stack_pop <= 1'b0;
      st.push_op   <= 1'b0;
      st.sub_op    <= 1'b0;
      st.ret_op    <= 1'b0;
      st.busy      <= 1'b0;
      st.opnd      <= '0;
    end else begin
      st <= next_st;
    end
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // The busy flag has its own flop so that the core never sees a decode glitch on it.
  // It rises on the same edge as the return's pc_load_o, which is the cycle the target is fetched.
  assign mem_wr_o              = st.mem_wr;
  assign pc_load_o             = st.pc_load;
  assign pc_value_o            = st.pc_value;
  assign stack_pop_o           = st.stack_pop;
  assign busy_o                = st.busy;
  assign push_literal_op_o     = st.push_op;
  assign pointer_subtract_op_o = st.sub_op;
  assign stack_sub_return_op_o = st.ret_op;
  assign ptr_o                 = st.ptr;
  assign opnd_rsp_o            = st.opnd;

endmodule

// ==== verilog/esd_opnd_addr.sv ====
// Operand address former for byte- and bit-oriented standard instructions.
// Purely combinational; the caller registers the result on the core clock.
`timescale 1ns/1ns
module esd_opnd_addr (
  // Operand request and context
  input  wire esd_pkg::esd_opnd_req_type          req_i,
  input  wire logic                               ext_en_i,
  input  wire logic [3:0]                         bank_select_reg_i,
  input  wire logic [esd_pkg::ADDR_W-1:0]         soft_stack_pointer_i,
  // Resolved operand
  output esd_pkg::esd_opnd_rsp_type               rsp_o
);

  logic idx;

  always_comb begin
    // Index form only when extended, access bit clear and offset in range.
    idx           = ext_en_i && !req_i.access && (req_i.file <= esd_pkg::INDEX_MAX);
    rsp_o.valid   = req_i.valid;
    rsp_o.indexed = idx;
    // Destination select keeps its plain meaning in both modes.
    rsp_o.to_wreg = !req_i.dest;
    if (idx) begin
      // Pointer plus zero-extended offset, wrapping at the data space.
      rsp_o.addr = soft_stack_pointer_i + {4'h0, req_i.file};
    end else if (req_i.access) begin
      // Banked literal address.
      rsp_o.addr = {bank_select_reg_i, req_i.file};
    end else if (req_i.file < esd_pkg::ACC_LOW_LIMIT) begin
      // Lower access bank.
      rsp_o.addr = {4'h0, req_i.file};
    end else begin
      // Upper access bank holds the special registers.
      rsp_o.addr = {esd_pkg::ACC_HIGH_BANK, req_i.file};
    end
  end

endmodule

// ==== verilog/esd_pkg.sv ====
// Package for the extended stack-op and indexed-operand decode block.
// Assumes one core clock; all users reference items as esd_pkg::name.
package esd_pkg;

  // ************************************************************
  // Widths, opcodes and address map
  // ************************************************************
  localparam int          ADDR_W        = 12;
  localparam int          NUM_PTR       = 3;
  localparam logic [7:0]  OPC_PUSH_LIT  = 8'hea;
  localparam logic [7:0]  OPC_PTR_SUB   = 8'he9;
  localparam logic [1:0]  SEL_SUB_RET   = 2'h3;
  localparam int          SEL_POS       = 6;
  localparam int          IMM6_W        = 6;
  localparam logic [7:0]  INDEX_MAX     = 8'h5f;
  localparam logic [7:0]  ACC_LOW_LIMIT = 8'h60;
  localparam logic [3:0]  ACC_HIGH_BANK = 4'hf;
  localparam logic [11:0] PTR_RESET     = 12'h000;
  localparam int          SOFT_SP_IDX   = 2;

  // ************************************************************
  // Carriers
  // ************************************************************
  typedef struct packed {
    logic              we;
    logic [ADDR_W-1:0] addr;
    logic [7:0]        data;
  } esd_mem_wr_type;

  typedef struct packed {
    logic       valid;
    logic [7:0] file;
    logic       access;
    logic       dest;
  } esd_opnd_req_type;

  typedef struct packed {
    logic              valid;
    logic [ADDR_W-1:0] addr;
    logic              indexed;
    logic              to_wreg;
  } esd_opnd_rsp_type;

  typedef struct packed {
    logic              load;
    logic [ADDR_W-1:0] value;
    logic [1:0]        sel;
  } esd_ptr_wr_type;

  typedef enum logic [0:0] {
    ST_EXEC,
    ST_RET_NOP
  } esd_phase_type;

endpackage
